//--- design/mcu_core.sv
// 8-bit accumulator core: fetch, decode, execute, data memory and call stack
// assumes a program memory that returns pmem_data for pmem_addr within one
// instruction cycle; port_in comes from pins
//
// What this block does
// - ordinary instructions take one cycle; branch, call, table read take two
// - every instruction cycle lasts exactly four system clocks
// - jump, call, return and interrupt return each add one cycle
// - writing the program counter low byte jumps there and adds one cycle
// - skip instructions take one cycle, two when the skip happens
// - skips test a memory byte or bit, then run or skip the next
// - add sets carry above 255, subtract sets carry as borrow below 0
// - increment and decrement by exactly one, result to memory or accumulator
// - logic and complement results set zero when zero, clear it otherwise
// - rotates move one bit right or left, plain ones wrap within the byte
// - rotate through carry sends leaving bit to carry, old carry enters
// - call saves the next address, return resumes exactly there
// - jump loads the target without saving a return address
// - transfers move memory to accumulator, accumulator to memory, or immediate
// - arithmetic and logic use the accumulator, result to accumulator or memory
// - bit set and clear change one bit, keeping the others, output port included; writes to the input port are dropped
`timescale 1ns/1ps
`default_nettype none
`include "core_cfg.svh"

module mcu_core
    import core_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // program memory
    output logic [`PC_W-1:0] pmem_addr,
    input wire logic [`WORD_W-1:0] pmem_data,
    // port pins
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    // observed core state
    output logic [7:0] acc_out,
    output flags_type flags_out
);

    // reset release through two flip-flops
    logic rst_s1_r;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // port input synchroniser, a change counts once stages two and three agree
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic [7:0] pin_s3_r;
    logic [7:0] pin_r;
    logic [7:0] pin_nxt;

    always_comb
    begin
        pin_nxt = (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_r;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            pin_s3_r <= 8'h00;
            pin_r <= 8'h00;
        end
        else
        begin
            pin_s1_r <= port_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_r <= pin_nxt;
        end
    end

    // core state
    logic [`PHASE_W-1:0] phase_r, phase_nxt;
    core_state_type st_r, st_nxt;
    logic [`PC_W-1:0] pc_r, pc_nxt;
    logic [`WORD_W-1:0] ir_r, ir_nxt;
    logic [7:0] acc_r, acc_nxt;
    flags_type flg_r, flg_nxt;
    logic [7:0] port_r, port_nxt;
    logic [`SP_W-1:0] sp_r, sp_nxt;
    logic [7:0] dmem_r [0:`DMEM_DEPTH-1];
    logic [`PC_W-1:0] stack_r [0:`STACK_DEPTH-1];
    logic mem_we;
    logic push;
    logic [`SP_W-1:0] sp_dec;

    instr_type ins;
    logic [7:0] imm;
    logic [`PC_W-1:0] target;
    logic last_phase;
    logic [7:0] rd_data;
    logic [7:0] src;
    logic [8:0] wide;
    logic [7:0] bit_mask;
    logic [7:0] res;
    logic c_res;
    logic wr_acc, wr_mem, upd_c, upd_z, skip;

    assign ins = instr_type'(ir_r);
    assign imm = ir_r[`IMM_MSB:0];
    assign target = ir_r[`TARGET_MSB:0];
    assign last_phase = (phase_r == `PHASE_LAST);
    assign sp_dec = sp_r - `SP_W'(1);
    assign bit_mask = 8'h01 << ins.bit_sel;
    assign port_out = port_r;
    assign acc_out = acc_r;
    assign flags_out = flg_r;

    // table read cycle fetches from the table pointer in the current page
    assign pmem_addr = (st_r == st_table) ?
        {pc_r[`PC_W-1:`PC_W-`PAGE_W], dmem_r[`TABLE_PTR_ADDR]} : pc_r;

    // data memory read with special locations overlaid
    always_comb
    begin
        if (ins.addr == `PROG_COUNTER_LOW_BYTE_ADDR)
            rd_data = pc_r[7:0];
        else if (ins.addr == `STATUS_ADDR)
            rd_data = {6'h00, flg_r.zero, flg_r.carry};
        else if (ins.addr == `PORT_OUT_ADDR)
            rd_data = port_r;
        else if (ins.addr == `PORT_IN_ADDR)
            rd_data = pin_r;
        else
            rd_data = dmem_r[ins.addr];
    end

    // execute unit
    always_comb
    begin
        src = rd_data;
        wide = 9'h000;
        res = 8'h00;
        c_res = flg_r.carry;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        upd_c = 1'b0;
        upd_z = 1'b0;
        skip = 1'b0;
        case (ins.op)
            `TRANSFER_IMM_OP, `ADD_IMM_OP, `SUBTRACT_IMM_OP, `AND_IMM_OP:
                src = imm;
            default:
                src = rd_data;
        endcase
        case (ins.op)
            `ADD_OP, `ADD_CARRY_OP, `ADD_IMM_OP:
            begin
                wide = {1'b0, acc_r} + {1'b0, src}
                    + {8'h00, (ins.op == `ADD_CARRY_OP) & flg_r.carry};
                res = wide[7:0];
                c_res = wide[8];
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            `SUBTRACT_OP, `SUBTRACT_BORROW_OP, `SUBTRACT_IMM_OP:
            begin
                wide = {1'b0, acc_r} - {1'b0, src}
                    - {8'h00, (ins.op == `SUBTRACT_BORROW_OP) & flg_r.carry};
                res = wide[7:0];
                c_res = wide[8];
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            `AND_OP, `AND_IMM_OP:
            begin
                res = acc_r & src;
                upd_z = 1'b1;
            end
            `OR_OP:
            begin
                res = acc_r | src;
                upd_z = 1'b1;
            end
            `XOR_OP:
            begin
                res = acc_r ^ src;
                upd_z = 1'b1;
            end
            `COMPLEMENT_OP:
            begin
                res = ~src;
                upd_z = 1'b1;
            end
            `INCREMENT_OP:
            begin
                res = src + 8'h01;
                upd_z = 1'b1;
            end
            `DECREMENT_OP:
            begin
                res = src - 8'h01;
                upd_z = 1'b1;
            end
            `ROTATE_RIGHT_OP:
                res = {src[0], src[7:1]};
            `ROTATE_LEFT_OP:
                res = {src[6:0], src[7]};
            `ROTATE_RIGHT_VIA_CARRY_OP:
            begin
                res = {flg_r.carry, src[7:1]};
                c_res = src[0];
                upd_c = 1'b1;
            end
            `ROTATE_LEFT_VIA_CARRY_OP:
            begin
                res = {src[6:0], flg_r.carry};
                c_res = src[7];
                upd_c = 1'b1;
            end
            `TRANSFER_TO_ACC_OP, `TRANSFER_IMM_OP:
                res = src;
            `TRANSFER_TO_MEM_OP:
                res = acc_r;
            `BIT_SET_OP:
                res = rd_data | bit_mask;
            `BIT_CLEAR_OP:
                res = rd_data & ~bit_mask;
            `SKIP_ZERO_OP:
                skip = (rd_data == 8'h00);
            `SKIP_BIT_ZERO_OP:
                skip = ((rd_data & bit_mask) == 8'h00);
            `SKIP_BIT_ONE_OP:
                skip = ((rd_data & bit_mask) != 8'h00);
            default:
                res = 8'h00;
        endcase
        // destination choice
        case (ins.op)
            `ADD_OP, `ADD_CARRY_OP, `SUBTRACT_OP, `SUBTRACT_BORROW_OP,
            `AND_OP, `OR_OP, `XOR_OP, `COMPLEMENT_OP, `INCREMENT_OP,
            `DECREMENT_OP, `ROTATE_RIGHT_OP, `ROTATE_LEFT_OP,
            `ROTATE_RIGHT_VIA_CARRY_OP, `ROTATE_LEFT_VIA_CARRY_OP:
            begin
                wr_mem = ins.to_mem;
                wr_acc = ~ins.to_mem;
            end
            `TRANSFER_TO_ACC_OP, `TRANSFER_IMM_OP, `ADD_IMM_OP,
            `SUBTRACT_IMM_OP, `AND_IMM_OP:
                wr_acc = 1'b1;
            `TRANSFER_TO_MEM_OP, `BIT_SET_OP, `BIT_CLEAR_OP:
                wr_mem = 1'b1;
            default:
                wr_acc = 1'b0;
        endcase
    end

    // sequencing; all state but the phase counter moves on the last clock of an instruction cycle
    always_comb
    begin
        phase_nxt = last_phase ? `PHASE_W'(0) : phase_r + `PHASE_W'(1);
        st_nxt = st_r;
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        acc_nxt = acc_r;
        flg_nxt = flg_r;
        port_nxt = port_r;
        sp_nxt = sp_r;
        mem_we = 1'b0;
        push = 1'b0;
        if (last_phase)
        begin
            case (st_r)
                st_exec:
                begin
                    ir_nxt = pmem_data;
                    pc_nxt = pc_r + `PC_W'(1);
                    if (wr_acc)
                        acc_nxt = res;
                    if (wr_mem)
                    begin
                        if (ins.addr == `PROG_COUNTER_LOW_BYTE_ADDR)
                        begin
                            pc_nxt = {pc_r[`PC_W-1:8], res};
                            st_nxt = st_flush;
                        end
                        else if (ins.addr == `STATUS_ADDR)
                        begin
                            flg_nxt.carry = res[`STATUS_CARRY_BIT];
                            flg_nxt.zero = res[`STATUS_ZERO_BIT];
                        end
                        else if (ins.addr == `PORT_OUT_ADDR)
                            port_nxt = res;
                        else if (ins.addr != `PORT_IN_ADDR)
                            mem_we = 1'b1;
                    end
                    if (upd_c)
                        flg_nxt.carry = c_res;
                    if (upd_z)
                        flg_nxt.zero = (res == 8'h00);
                    if (skip)
                    begin
                        pc_nxt = pc_r + `PC_W'(1);
                        st_nxt = st_flush;
                    end
                    case (ins.op)
                        `UNCOND_BRANCH_OP:
                        begin
                            pc_nxt = target;
                            st_nxt = st_flush;
                        end
                        `SUBROUTINE_CALL_OP:
                        begin
                            push = 1'b1;
                            sp_nxt = sp_r + `SP_W'(1);
                            pc_nxt = target;
                            st_nxt = st_flush;
                        end
                        `SUBROUTINE_RETURN_OP, `INTERRUPT_RETURN_OP:
                        begin
                            pc_nxt = stack_r[sp_dec];
                            sp_nxt = sp_dec;
                            st_nxt = st_flush;
                        end
                        `TABLE_READ_OP:
                            st_nxt = st_table;
                        default:
                            st_nxt = st_nxt;
                    endcase
                end
                st_flush:
                begin
                    ir_nxt = pmem_data;
                    pc_nxt = pc_r + `PC_W'(1);
                    st_nxt = st_exec;
                end
                default:
                begin
                    acc_nxt = pmem_data[7:0];
                    st_nxt = st_exec;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            phase_r <= `PHASE_W'(0);
            st_r <= st_flush;
            pc_r <= `PC_RESET;
            ir_r <= `IR_RESET;
            acc_r <= `ACC_RESET;
            flg_r <= '0;
            port_r <= `PORT_RESET;
            sp_r <= `SP_W'(0);
        end
        else
        begin
            phase_r <= phase_nxt;
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            acc_r <= acc_nxt;
            flg_r <= flg_nxt;
            port_r <= port_nxt;
            sp_r <= sp_nxt;
        end
    end

    // data memory and return stack storage
    always_ff @(posedge clk)
    begin
        if (mem_we)
            dmem_r[ins.addr] <= res;
        if (push)
            stack_r[sp_r] <= pc_r;
    end

endmodule
`default_nettype wire

//--- design/core_cfg.svh
// offsets, field positions, reset values, opcodes and timing counts of the core
// assumes nothing; included by the package and the core
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// system clock, one instruction cycle in system clocks
`define CLK_PERIOD_NS 8
`define ICYCLE_CLKS 4
`define PHASE_W 2
`define PHASE_LAST (`PHASE_W'(`ICYCLE_CLKS - 1))

// widths
`define PC_W 11
`define PAGE_W 3
`define WORD_W 16
`define DADDR_W 7
`define DMEM_DEPTH 128
`define STACK_DEPTH 8
`define SP_W 3

// instruction word fields
`define IMM_MSB 7
`define TARGET_MSB 10

// special data memory locations
`define PROG_COUNTER_LOW_BYTE_ADDR 7'h06
`define TABLE_PTR_ADDR 7'h07
`define STATUS_ADDR 7'h0a
`define PORT_OUT_ADDR 7'h12
`define PORT_IN_ADDR 7'h13

// status register bits
`define STATUS_CARRY_BIT 0
`define STATUS_ZERO_BIT 1

// reset values
`define PC_RESET 11'h000
`define ACC_RESET 8'h00
`define PORT_RESET 8'h00
`define IR_RESET 16'h0000

// opcodes, instruction word bits 15:11
`define NOP_OP 5'h00
`define ADD_OP 5'h01
`define ADD_CARRY_OP 5'h02
`define SUBTRACT_OP 5'h03
`define SUBTRACT_BORROW_OP 5'h04
`define AND_OP 5'h05
`define OR_OP 5'h06
`define XOR_OP 5'h07
`define COMPLEMENT_OP 5'h08
`define INCREMENT_OP 5'h09
`define DECREMENT_OP 5'h0a
`define ROTATE_RIGHT_OP 5'h0b
`define ROTATE_LEFT_OP 5'h0c
`define ROTATE_RIGHT_VIA_CARRY_OP 5'h0d
`define ROTATE_LEFT_VIA_CARRY_OP 5'h0e
`define TRANSFER_TO_ACC_OP 5'h0f
`define TRANSFER_TO_MEM_OP 5'h10
`define TRANSFER_IMM_OP 5'h11
`define ADD_IMM_OP 5'h12
`define SUBTRACT_IMM_OP 5'h13
`define AND_IMM_OP 5'h14
`define BIT_SET_OP 5'h15
`define BIT_CLEAR_OP 5'h16
`define SKIP_ZERO_OP 5'h17
`define SKIP_BIT_ZERO_OP 5'h18
`define SKIP_BIT_ONE_OP 5'h19
`define UNCOND_BRANCH_OP 5'h1a
`define SUBROUTINE_CALL_OP 5'h1b
`define SUBROUTINE_RETURN_OP 5'h1c
`define INTERRUPT_RETURN_OP 5'h1d
`define TABLE_READ_OP 5'h1e

`endif

//--- design/core_pkg.sv
// types shared by the core and the bench
// assumes core_cfg.svh on the include path
`default_nettype none
`include "core_cfg.svh"

package core_pkg;

    typedef struct packed {
        logic [4:0] op;
        logic to_mem;
        logic [2:0] bit_sel;
        logic [`DADDR_W-1:0] addr;
    } instr_type;

    typedef struct packed {
        logic zero;
        logic carry;
    } flags_type;

    typedef enum logic [1:0] {
        st_exec,
        st_flush,
        st_table
    } core_state_type;

endpackage
`default_nettype wire

//--- testbench/mcu_core_monitor.sv
// checker for mcu_core: cycle framing, fetch flow and result relations
// assumes it is bound to mcu_core and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
`include "core_cfg.svh"

module mcu_core_monitor
    import core_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // program memory
    input wire logic [`PC_W-1:0] pmem_addr,
    input wire logic [`WORD_W-1:0] pmem_data,
    // pins and core state
    input wire logic [7:0] port_in,
    input wire logic [7:0] port_out,
    input wire logic [7:0] acc_out,
    input wire flags_type flags_out
);
    logic [`PC_W-1:0] addr_r;
    logic [`WORD_W-1:0] word_r;
    logic go;
    logic [4:0] op;

    // last address and word; a moved address marks a cycle boundary
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_r <= '0;
            word_r <= '0;
        end
        else
        begin
            addr_r <= pmem_addr;
            word_r <= pmem_data;
        end
    end

    assign go = pmem_addr != addr_r;
    assign op = word_r[15:11];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    addr_hold_a: assert property (go |=> $stable(pmem_addr)[*3])
        else $error("fetch address moved inside a cycle");
    out_edge_a: assert property ($changed({acc_out, flags_out, port_out}) |-> go)
        else $error("state changed off a cycle boundary");
    step_next_a: assert property (go && op inside {[`ADD_OP:`TRANSFER_TO_ACC_OP]} && !word_r[10]
        |-> ##4 pmem_addr == $past(pmem_addr, 4) + 1'b1)
        else $error("one cycle op did not step to next word");
    jump_dest_a: assert property (go && op == `UNCOND_BRANCH_OP
        |-> ##4 pmem_addr == $past(word_r[10:0], 4))
        else $error("jump target wrong");
    call_dest_a: assert property (go && op == `SUBROUTINE_CALL_OP
        |-> ##4 pmem_addr == $past(word_r[10:0], 4))
        else $error("call target wrong");
    pcl_jump_a: assert property (go && op == `TRANSFER_TO_MEM_OP
        && word_r[6:0] == `PROG_COUNTER_LOW_BYTE_ADDR
        |-> ##4 pmem_addr == {$past(pmem_addr[10:8], 4), $past(acc_out, 4)})
        else $error("low byte write did not jump");
    imm_load_a: assert property (go && op == `TRANSFER_IMM_OP |-> ##4
        acc_out == $past(word_r[7:0], 4) && flags_out == $past(flags_out, 4))
        else $error("immediate load wrong");
    add_imm_a: assert property (go && op == `ADD_IMM_OP |-> ##4
        {flags_out.carry, acc_out} == $past(acc_out, 4) + $past(word_r[7:0], 4))
        else $error("immediate add or carry wrong");
    rot_flags_a: assert property (go && op inside {`ROTATE_RIGHT_OP, `ROTATE_LEFT_OP}
        |-> ##4 flags_out == $past(flags_out, 4))
        else $error("plain rotate touched flags");
    logic_zero_a: assert property (go && !word_r[10]
        && op inside {`AND_OP, `OR_OP, `XOR_OP, `COMPLEMENT_OP}
        |-> ##4 flags_out.zero == (acc_out == 8'h00))
        else $error("logic zero flag wrong");
endmodule

bind mcu_core mcu_core_monitor mon (.clk(clk), .rst_n(rst_n), .pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .port_in(port_in), .port_out(port_out), .acc_out(acc_out),
    .flags_out(flags_out));
`default_nettype wire

//--- testbench/mcu_core_tb.sv
// bench for mcu_core: builds a program beside a reference model, then
// checks each port_out change and the clocks between changes
// assumes core_pkg and core_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "core_cfg.svh"

`define CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) \
        begin \
            miscompares++; \
            $display("unexpected %s expected %h seen %h", nm, ex, got); \
        end \
    end

module mcu_core_tb
    import core_pkg::*;
;
    localparam int LIMIT = 4000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`PC_W-1:0] pmem_addr;
    logic [`WORD_W-1:0] pmem_data = '0;
    logic [7:0] port_in = '0;
    logic [7:0] port_out;
    logic [7:0] acc_out;
    flags_type flags_out;
    logic [15:0] prog [0:2047];
    logic [7:0] dm [0:127];
    logic [7:0] ev [$];
    int ed [$];
    logic [7:0] ma, last, pin, ex;
    logic [7:0] seen_port = 8'h00;
    logic mc, mz;
    int p, gap, span, d, notes_done, cyc, miscompares, check_count;
    int seed = 32'h7272;

    mcu_core uut (.clk(clk), .rst_n(rst_n), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .port_in(port_in), .port_out(port_out), .acc_out(acc_out), .flags_out(flags_out));

    always #4 clk = ~clk;

    task automatic close_out();
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [15:0] w(logic [4:0] o, logic tm, logic [2:0] b, logic [6:0] a);
        return {o, tm, b, a};
    endfunction

    task automatic e(input logic [15:0] word, input int n);
        prog[p] = word;
        p++;
        gap += 4 * n;
    endtask

    // expect a port change only when the value really differs
    task automatic note(input logic [7:0] v);
        if (v !== last)
        begin
            ev.push_back(v);
            ed.push_back(gap);
            gap = 0;
            last = v;
        end
    endtask

    task automatic put();
        e(w(`TRANSFER_TO_MEM_OP, 1'b1, 3'd0, `PORT_OUT_ADDR), 1);
        note(ma);
    endtask

    task automatic ld(input logic [7:0] v);
        e({`TRANSFER_IMM_OP, 3'b000, v}, 1);
        ma = v;
    endtask

    task automatic set_m(input logic [6:0] a, input logic [7:0] v);
        ld(v);
        e(w(`TRANSFER_TO_MEM_OP, 1'b1, 3'd0, a), 1);
        dm[a] = v;
    endtask

    // a word that is discarded unless run is set; it bumps port_out if it runs
    task automatic junk(input bit run);
        prog[p] = w(`INCREMENT_OP, 1'b1, 3'd0, `PORT_OUT_ADDR);
        p++;
        if (run)
        begin
            gap += 4;
            note(last + 8'h01);
        end
    endtask

    // status to port, masked to {zero, carry}
    task automatic st();
        e(w(`TRANSFER_TO_ACC_OP, 1'b0, 3'd0, `STATUS_ADDR), 1);
        e({`AND_IMM_OP, 3'b000, 8'h03}, 1);
        ma = {6'h00, mz, mc};
        mz = ma == 8'h00;
        put();
    endtask

    task automatic alu(input logic [4:0] o, input logic [6:0] a);
        logic [8:0] r;
        logic [7:0] m;
        m = dm[a];
        r = {mc, ma};
        case (o)
            `ADD_OP: r = ma + m;
            `ADD_CARRY_OP: r = ma + m + mc;
            `SUBTRACT_OP: r = {1'b0, ma} - m;
            `SUBTRACT_BORROW_OP: r = {1'b0, ma} - m - mc;
            `AND_OP: r = {mc, ma & m};
            `OR_OP: r = {mc, ma | m};
            `XOR_OP: r = {mc, ma ^ m};
            `COMPLEMENT_OP: r = {mc, ~m};
            `INCREMENT_OP: r = {mc, m + 8'h01};
            `DECREMENT_OP: r = {mc, m - 8'h01};
            `ROTATE_RIGHT_OP: r = {mc, m[0], m[7:1]};
            `ROTATE_LEFT_OP: r = {mc, m[6:0], m[7]};
            `ROTATE_RIGHT_VIA_CARRY_OP: r = {m[0], mc, m[7:1]};
            default: r = {m[7], m[6:0], mc};
        endcase
        if (o < `ROTATE_RIGHT_OP)
            mz = r[7:0] == 8'h00;
        mc = r[8];
        ma = r[7:0];
        e(w(o, 1'b0, 3'd0, a), 1);
        put();
    endtask

    always @(posedge clk)
    begin
        #1;
        pmem_data = prog[pmem_addr];
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            miscompares++;
            close_out();
        end
    end

    // result watcher: each port change takes the oldest note
    always @(negedge clk)
    begin
        span++;
        if (port_out !== seen_port)
        begin
            if (ev.size() == 0)
                `CHK("port_out", seen_port, port_out)
            else
            begin
                ex = ev.pop_front();
                d = ed.pop_front();
                `CHK("port_out", ex, port_out)
                if (notes_done != 0)
                    `CHK("clocks between changes", d, span)
                notes_done++;
            end
            seen_port = port_out;
            span = 0;
        end
    end

    initial
    begin
        logic [4:0] ops [7];
        int i, k, x, q;
        logic [7:0] a, v;
        logic tk;
        ops = '{`ADD_OP, `ADD_CARRY_OP, `SUBTRACT_OP, `SUBTRACT_BORROW_OP,
            `AND_OP, `OR_OP, `XOR_OP};
        for (i = 0; i < 2048; i++)
            prog[i] = '0;
        last = 8'h00;
        mc = 1'b0;
        mz = 1'b0;
        pin = 8'($random(seed));
        port_in = pin;
        // control flow first, so the low byte jump stays in page 0
        e({`UNCOND_BRANCH_OP, 11'(p + 2)}, 2);
        junk(1'b0);
        ld(8'h3c);
        put();
        ld(8'(p + 3));
        e(w(`TRANSFER_TO_MEM_OP, 1'b1, 3'd0, `PROG_COUNTER_LOW_BYTE_ADDR), 2);
        junk(1'b0);
        for (k = 0; k < 2; k++)
        begin
            ld(8'h70 + 8'(k));
            put();
            e({`SUBROUTINE_CALL_OP, 11'h400 + 11'(16 * k)}, 2);
            q = p;
            p = 'h400 + 16 * k;
            ld(8'ha0 + 8'(k));
            put();
            e({k ? `INTERRUPT_RETURN_OP : `SUBROUTINE_RETURN_OP, 11'h000}, 2);
            junk(1'b0);
            p = q;
            put();
        end
        for (k = 0; k < 6; k++)
        begin
            v = (k == 0) ? 8'h00 : 8'($random(seed));
            x = {$random(seed)} % 8;
            set_m(7'h22, v);
            tk = (k % 3 == 0) ? v == 8'h00 : (k % 3 == 1) ? !v[x] : v[x];
            e(w(`SKIP_ZERO_OP + 5'(k % 3), 1'b0, 3'(x), 7'h22), tk ? 2 : 1);
            junk(!tk);
        end
        ld(8'hff);
        e({`ADD_IMM_OP, 3'b000, 8'h01}, 1);
        {mc, ma} = 9'(ma) + 9'h001;
        mz = ma == 8'h00;
        put();
        st();
        for (i = 0; i < 14; i++)
        begin
            a = (i == 0 || i == 2) ? 8'h01 : 8'($random(seed));
            v = (i == 0) ? 8'hff : (i == 2) ? 8'h00 : 8'($random(seed));
            set_m(7'h20, a);
            ld(v);
            alu(ops[i % 7], 7'h20);
            st();
        end
        for (k = 0; k < 2; k++)
        begin
            set_m(7'h21, 8'($random(seed)));
            for (i = `COMPLEMENT_OP; i <= `ROTATE_LEFT_VIA_CARRY_OP; i++)
                alu(5'(i), 7'h21);
        end
        e(w(`INCREMENT_OP, 1'b1, 3'd0, 7'h21), 1);
        dm[7'h21] = dm[7'h21] + 8'h01;
        mz = dm[7'h21] == 8'h00;
        e(w(`TRANSFER_TO_ACC_OP, 1'b0, 3'd0, 7'h21), 1);
        ma = dm[7'h21];
        put();
        for (k = 0; k < 4; k++)
        begin
            x = {$random(seed)} % 8;
            e(w(`BIT_SET_OP, 1'b1, 3'(x), `PORT_OUT_ADDR), 1);
            note(last | (8'h01 << x));
            x = {$random(seed)} % 8;
            e(w(`BIT_CLEAR_OP, 1'b1, 3'(x), `PORT_OUT_ADDR), 1);
            note(last & ~(8'h01 << x));
        end
        e(w(`TRANSFER_TO_ACC_OP, 1'b0, 3'd0, `PORT_IN_ADDR), 1);
        ma = pin;
        put();
        e({`UNCOND_BRANCH_OP, 11'(p)}, 2);
        junk(1'b0);
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        while (ev.size() != 0)
            @(posedge clk);
        repeat (8) @(posedge clk);
        close_out();
    end
endmodule
`default_nettype wire
